// ---- src/asc_pkg.sv ----
package asc_pkg;

    // register word index on the plain register port
    localparam logic [2:0] REG_CON1   = 3'h0;
    localparam logic [2:0] REG_CON2   = 3'h1;
    localparam logic [2:0] REG_CON3   = 3'h2;
    localparam logic [2:0] REG_CON4   = 3'h3;
    localparam logic [2:0] REG_RESULT = 3'h4;
    localparam logic [2:0] REG_DMA    = 3'h5;

    // converter_control_one field positions
    localparam int B_ON     = 15;
    localparam int B_SIDL   = 13;
    localparam int B_BM     = 12;
    localparam int B_12B    = 10;
    localparam int B_FMT    = 8;
    localparam int B_SSRC   = 5;
    localparam int B_SIMULTANEOUS_SAMPLE = 3;
    localparam int B_AUTO_SAMPLE_START   = 2;
    localparam int B_SAMPLE_CONTROL   = 1;
    localparam int B_DONE   = 0;
    // converter_control_two, three and four field positions
    localparam int B_CHPS   = 8;
    localparam int B_SMPI   = 2;
    localparam int B_SAMC   = 8;
    localparam int B_DMABL  = 0;

    // implemented bits of each register, and the reset value of all four
    localparam logic [15:0] C1_MASK = 16'hb7ef;
    localparam logic [15:0] C2_MASK = 16'he73f;
    localparam logic [15:0] C3_MASK = 16'h9fff;
    localparam logic [15:0] C4_MASK = 16'h0007;
    localparam logic [15:0] RST_CON = 16'h0000;

    // trigger_source codes
    localparam logic [2:0] TRG_MANUAL  = 3'h0;
    localparam logic [2:0] TRG_EXT_INT = 3'h1;
    localparam logic [2:0] TRG_TIMER   = 3'h2;
    localparam logic [2:0] TRG_COUNTER = 3'h7;

    // result_format codes
    localparam logic [1:0] FMT_SIGNED = 2'h1;

    typedef enum logic [1:0] {
        ST_OFF    = 2'b00,
        ST_HOLD   = 2'b01,
        ST_SAMPLE = 2'b11,
        ST_CONV   = 2'b10
    } asc_state_e;

    function automatic logic trg_reserved(input logic [2:0] code);
        return (code >= 3'h3) && (code <= 3'h6);
    endfunction

endpackage

// ---- src/asc_conv_if.sv ----
`timescale 1ns/1ps
interface asc_conv_if;
    logic [11:0] raw;
    logic        res12;
    logic [1:0]  fmt;
    logic [15:0] fmt_out;
    logic        step;
    logic        grp_end;
    logic [4:0]  chan;
    logic        build_order;
    logic [2:0]  buf_len;
    logic [11:0] dma_addr;

    modport ctl (output raw, res12, fmt, step, grp_end, chan, build_order, buf_len, input fmt_out, dma_addr);
    modport fmt_side (input raw, res12, fmt, output fmt_out);
    modport dma_side (input step, grp_end, chan, build_order, buf_len, output dma_addr);
endinterface

// ---- src/asc_format.sv ----
`timescale 1ns/1ps
module asc_format (
    asc_conv_if.fmt_side cv
);
    // reserved codes fall back to plain integer form
    always_comb begin
        if (cv.res12) begin
            if (cv.fmt == asc_pkg::FMT_SIGNED) begin
                cv.fmt_out = {{5{~cv.raw[11]}}, cv.raw[10:0]};
            end else begin
                cv.fmt_out = {4'h0, cv.raw[11:0]};
            end
        end else begin
            if (cv.fmt == asc_pkg::FMT_SIGNED) begin
                cv.fmt_out = {{7{~cv.raw[9]}}, cv.raw[8:0]};
            end else begin
                cv.fmt_out = {6'h00, cv.raw[9:0]};
            end
        end
    end
endmodule // asc_format

// ---- src/asc_dma_addr.sv ----
`timescale 1ns/1ps
module asc_dma_addr (
    input  wire logic    clk,
    input  wire logic    sys_rst,
    input  wire logic    run,
    asc_conv_if.dma_side cv
);
    logic [3:0]  seq_r;
    logic [3:0]  seq_nxt;
    logic [6:0]  ptr_r;
    logic [6:0]  ptr_nxt;
    logic [11:0] addr_r;
    logic [11:0] addr_nxt;
    logic [11:0] chan_part;
    logic [6:0]  ptr_mask;

    assign cv.dma_addr = addr_r;

    always_comb begin
        seq_nxt   = seq_r;
        ptr_nxt   = ptr_r;
        addr_nxt  = addr_r;
        chan_part = {cv.chan, 7'h00} >> (3'h7 - cv.buf_len);
        ptr_mask  = 7'h7f >> (3'h7 - cv.buf_len);
        if (!run) begin
            seq_nxt = 4'h0;
            ptr_nxt = 7'h00;
        end else if (cv.step) begin
            if (cv.build_order) begin
                addr_nxt = {8'h00, seq_r};
            end else begin
                addr_nxt = chan_part | {5'h00, ptr_r & ptr_mask};
            end
            // pointer moves once per group of increment_rate+1 results
            if (cv.grp_end) begin
                seq_nxt = 4'h0;
                ptr_nxt = ptr_r + 7'h01;
            end else begin
                seq_nxt = seq_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            seq_r  <= 4'h0;
            ptr_r  <= 7'h00;
            addr_r <= 12'h000;
        end else begin
            seq_r  <= seq_nxt;
            ptr_r  <= ptr_nxt;
            addr_r <= addr_nxt;
        end
    end

    property p_order_addr;
        @(posedge clk) disable iff (sys_rst)
        (run && cv.step && cv.build_order) |=> (addr_r == {8'h00, $past(seq_r)});
    endproperty
    a_order_addr : assert property (p_order_addr) else $error("in-order dma address wrong");

    property p_ptr_adv;
        @(posedge clk) disable iff (sys_rst)
        (run && cv.step && cv.grp_end) |=> (ptr_r == $past(ptr_r) + 7'h01);
    endproperty
    a_ptr_adv : assert property (p_ptr_adv) else $error("dma pointer did not advance");
endmodule // asc_dma_addr

// ---- src/asc_ctl.sv ----
`timescale 1ns/1ps
module asc_ctl #(
    parameter int UNIT = 1
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        idle_mode,
    input  wire logic        external_interrupt_zero,
    input  wire logic        timer_cmp,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_data,
    input  wire logic [4:0]  conv_chan,
    output logic             sh_sample,
    output logic             conv_start,
    output logic             res_12bit,
    output logic             simul_sample,
    output logic      [15:0] result_word,
    output logic             conv_irq_flag,
    output logic             dma_req,
    output logic      [11:0] dma_addr
);
    ////////////////////////////////////////////////////////////////////////////
    asc_conv_if cv ();

    asc_format u_fmt (
        .cv (cv)
    );

    logic run;

    asc_dma_addr u_dma (
        .clk     (clk),
        .sys_rst (sys_rst),
        .run     (run),
        .cv      (cv)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0]          c1_r, c1_nxt;
    logic [15:0]          c2_r, c2_nxt;
    logic [15:0]          c3_r, c3_nxt;
    logic [15:0]          c4_r, c4_nxt;
    logic [15:0]          rdata_r, rdata_nxt;
    logic [15:0]          result_r, result_nxt;
    asc_pkg::asc_state_e  st_r, st_nxt;
    logic [4:0]           smp_cnt_r, smp_cnt_nxt;
    logic [3:0]           grp_cnt_r, grp_cnt_nxt;
    logic                 ext_d_r;
    logic                 start_r, start_nxt;
    logic                 irq_r, dma_r, grp_nxt;
    logic                 wr_c1, sw_end, trig_hit, ext_rise, fin;
    logic [2:0]           ssrc;
    logic [3:0]           smpi;

    assign ssrc     = c1_r[asc_pkg::B_SSRC +: 3];
    assign smpi     = c2_r[asc_pkg::B_SMPI +: 4];
    assign wr_c1    = reg_wr && (reg_addr == asc_pkg::REG_CON1);
    assign ext_rise = external_interrupt_zero && !ext_d_r;
    assign run      = c1_r[asc_pkg::B_ON] && !(c1_r[asc_pkg::B_SIDL] && idle_mode);
    assign sw_end   = wr_c1 && !reg_wdata[asc_pkg::B_SAMPLE_CONTROL];
    assign fin      = (st_r == asc_pkg::ST_CONV) && conv_done && run;

    assign cv.raw         = conv_data;
    assign cv.res12       = c1_r[asc_pkg::B_12B];
    assign cv.fmt         = c1_r[asc_pkg::B_FMT +: 2];
    assign cv.step        = fin;
    assign cv.grp_end     = fin && (grp_cnt_r == smpi);
    assign cv.chan        = conv_chan;
    assign cv.build_order = c1_r[asc_pkg::B_BM];
    assign cv.buf_len     = c4_r[asc_pkg::B_DMABL +: 3];

    assign reg_rdata     = rdata_r;
    assign sh_sample     = c1_r[asc_pkg::B_SAMPLE_CONTROL];
    assign conv_start    = start_r;
    assign res_12bit     = c1_r[asc_pkg::B_12B];
    assign simul_sample  = c1_r[asc_pkg::B_SIMULTANEOUS_SAMPLE];
    assign result_word   = result_r;
    assign conv_irq_flag = irq_r;
    assign dma_req       = dma_r;
    assign dma_addr      = cv.dma_addr;

    ////////////////////////////////////////////////////////////////////////////
    // end-of-sample trigger selection
    always_comb begin
        unique case (ssrc)
            asc_pkg::TRG_MANUAL:  trig_hit = sw_end;
            asc_pkg::TRG_EXT_INT: trig_hit = ext_rise;
            asc_pkg::TRG_TIMER:   trig_hit = timer_cmp;
            asc_pkg::TRG_COUNTER: trig_hit = (smp_cnt_r >= c3_r[asc_pkg::B_SAMC +: 5]);
            default:              trig_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers and sequencer
    always_comb begin
        c1_nxt      = c1_r;
        c2_nxt      = c2_r;
        c3_nxt      = c3_r;
        c4_nxt      = c4_r;
        st_nxt      = st_r;
        smp_cnt_nxt = smp_cnt_r;
        grp_cnt_nxt = grp_cnt_r;
        start_nxt   = 1'b0;
        grp_nxt     = 1'b0;
        result_nxt  = result_r;
        if (wr_c1) begin
            // sample bit is handled by the sequencer below; done is set by the sequencer and cleared by a write of zero
            c1_nxt[15:2] = reg_wdata[15:2] & asc_pkg::C1_MASK[15:2];
            c1_nxt[asc_pkg::B_SIMULTANEOUS_SAMPLE] = reg_wdata[asc_pkg::B_SIMULTANEOUS_SAMPLE] && !reg_wdata[asc_pkg::B_12B];
            if (!reg_wdata[asc_pkg::B_DONE]) begin
                c1_nxt[asc_pkg::B_DONE] = 1'b0;
            end
        end
        if (reg_wr && (reg_addr == asc_pkg::REG_CON2)) begin
            c2_nxt = reg_wdata & asc_pkg::C2_MASK;
        end
        if (reg_wr && (reg_addr == asc_pkg::REG_CON3)) begin
            c3_nxt = reg_wdata & asc_pkg::C3_MASK;
        end
        if (reg_wr && (reg_addr == asc_pkg::REG_CON4)) begin
            c4_nxt = reg_wdata & asc_pkg::C4_MASK;
        end
        if (!run) begin
            st_nxt                  = asc_pkg::ST_OFF;
            c1_nxt[asc_pkg::B_SAMPLE_CONTROL] = 1'b0;
            grp_cnt_nxt             = 4'h0;
        end else begin
            unique case (st_r)
                asc_pkg::ST_OFF: begin
                    st_nxt = asc_pkg::ST_HOLD;
                end
                asc_pkg::ST_HOLD: begin
                    if (c1_r[asc_pkg::B_AUTO_SAMPLE_START] || (wr_c1 && reg_wdata[asc_pkg::B_SAMPLE_CONTROL])) begin
                        st_nxt                  = asc_pkg::ST_SAMPLE;
                        c1_nxt[asc_pkg::B_SAMPLE_CONTROL] = 1'b1;
                        smp_cnt_nxt             = 5'h00;
                    end
                end
                asc_pkg::ST_SAMPLE: begin
                    if (smp_cnt_r != 5'h1f) begin
                        smp_cnt_nxt = smp_cnt_r + 5'h01;
                    end
                    if (trig_hit) begin
                        st_nxt                  = asc_pkg::ST_CONV;
                        c1_nxt[asc_pkg::B_SAMPLE_CONTROL] = 1'b0;
                        c1_nxt[asc_pkg::B_DONE] = 1'b0;
                        start_nxt               = 1'b1;
                    end
                end
                asc_pkg::ST_CONV: begin
                    if (conv_done) begin
                        result_nxt              = cv.fmt_out;
                        c1_nxt[asc_pkg::B_DONE] = 1'b1;
                        grp_nxt                 = cv.grp_end;
                        grp_cnt_nxt             = cv.grp_end ? 4'h0 : grp_cnt_r + 4'h1;
                        if (c1_r[asc_pkg::B_AUTO_SAMPLE_START]) begin
                            st_nxt                  = asc_pkg::ST_SAMPLE;
                            c1_nxt[asc_pkg::B_SAMPLE_CONTROL] = 1'b1;
                            smp_cnt_nxt             = 5'h00;
                        end else begin
                            st_nxt = asc_pkg::ST_HOLD;
                        end
                    end
                end
            endcase
        end
    end

    // read data: chps reads zero in 12-bit mode
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                asc_pkg::REG_CON1:   rdata_nxt = c1_r;
                asc_pkg::REG_CON2:   rdata_nxt = c1_r[asc_pkg::B_12B] ? (c2_r & ~16'h0300) : c2_r;
                asc_pkg::REG_CON3:   rdata_nxt = c3_r;
                asc_pkg::REG_CON4:   rdata_nxt = c4_r;
                asc_pkg::REG_RESULT: rdata_nxt = result_r;
                asc_pkg::REG_DMA:    rdata_nxt = {4'h0, cv.dma_addr};
                default:             rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            c1_r      <= asc_pkg::RST_CON;
            c2_r      <= asc_pkg::RST_CON;
            c3_r      <= asc_pkg::RST_CON;
            c4_r      <= asc_pkg::RST_CON;
            st_r      <= asc_pkg::ST_OFF;
            smp_cnt_r <= 5'h00;
            grp_cnt_r <= 4'h0;
            ext_d_r   <= 1'b0;
            start_r   <= 1'b0;
            irq_r     <= 1'b0;
            dma_r     <= 1'b0;
            result_r  <= 16'h0000;
            rdata_r   <= 16'h0000;
        end else begin
            c1_r      <= c1_nxt;
            c2_r      <= c2_nxt;
            c3_r      <= c3_nxt;
            c4_r      <= c4_nxt;
            st_r      <= st_nxt;
            smp_cnt_r <= smp_cnt_nxt;
            grp_cnt_r <= grp_cnt_nxt;
            ext_d_r   <= external_interrupt_zero;
            start_r   <= start_nxt;
            irq_r     <= grp_nxt;
            dma_r     <= grp_nxt;
            result_r  <= result_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_off;
        @(posedge clk) disable iff (sys_rst)
        !run |=> (st_r == asc_pkg::ST_OFF) && !sh_sample && !conv_start;
    endproperty
    a_off : assert property (p_off) else $error("module active while off or idle-stopped");

    property p_idle;
        @(posedge clk) disable iff (sys_rst)
        (c1_r[asc_pkg::B_SIDL] && idle_mode) |=> !sh_sample;
    endproperty
    a_idle : assert property (p_idle) else $error("sampling continued in idle");

    property p_no_simul;
        @(posedge clk) disable iff (sys_rst)
        res_12bit |-> !simul_sample;
    endproperty
    a_no_simul : assert property (p_no_simul) else $error("simultaneous sampling in 12-bit mode");

    property p_manual;
        @(posedge clk) disable iff (sys_rst)
        (run && st_r == asc_pkg::ST_SAMPLE && ssrc == asc_pkg::TRG_MANUAL && sw_end) |=> conv_start && !sh_sample;
    endproperty
    a_manual : assert property (p_manual) else $error("software clear did not start conversion");

    property p_ext;
        @(posedge clk) disable iff (sys_rst)
        (run && st_r == asc_pkg::ST_SAMPLE && ssrc == asc_pkg::TRG_EXT_INT && ext_rise) |=> conv_start;
    endproperty
    a_ext : assert property (p_ext) else $error("pin edge did not start conversion");

    property p_timer;
        @(posedge clk) disable iff (sys_rst)
        (run && st_r == asc_pkg::ST_SAMPLE && ssrc == asc_pkg::TRG_TIMER && timer_cmp) |=> conv_start;
    endproperty
    a_timer : assert property (p_timer) else $error("timer compare did not start conversion");

    property p_reserved;
        @(posedge clk) disable iff (sys_rst)
        asc_pkg::trg_reserved(ssrc) |=> !conv_start;
    endproperty
    a_reserved : assert property (p_reserved) else $error("reserved trigger started conversion");

    property p_done;
        @(posedge clk) disable iff (sys_rst)
        fin |=> c1_r[asc_pkg::B_DONE] && (result_word == $past(cv.fmt_out));
    endproperty
    a_done : assert property (p_done) else $error("done or result not captured");

    property p_auto;
        @(posedge clk) disable iff (sys_rst)
        (fin && c1_r[asc_pkg::B_AUTO_SAMPLE_START]) |=> sh_sample;
    endproperty
    a_auto : assert property (p_auto) else $error("auto-start did not resample");

    property p_irq_dma;
        @(posedge clk) disable iff (sys_rst)
        cv.grp_end |=> conv_irq_flag && dma_req ##1 !conv_irq_flag;
    endproperty
    a_irq_dma : assert property (p_irq_dma) else $error("group end flag or dma request wrong");

    property p_fmt10;
        @(posedge clk) disable iff (sys_rst)
        (fin && !cv.res12 && (cv.fmt == asc_pkg::FMT_SIGNED))
            |=> (result_word[15:9] == {7{~$past(conv_data[9])}});
    endproperty
    a_fmt10 : assert property (p_fmt10) else $error("10-bit signed fill wrong");
endmodule // asc_ctl

// ---- testbench/asc_core_model.sv ----
`timescale 1ns/1ps
module asc_core_model (
    input  wire logic        clk,
    input  wire logic        conv_start,
    input  wire logic [11:0] data_in,
    input  wire logic [4:0]  chan_in,
    output logic             conv_done,
    output logic      [11:0] conv_data,
    output logic      [4:0]  conv_chan
);
    int cnt = 0;
    initial begin
        conv_done = 1'b0;
        conv_data = 12'h000;
        conv_chan = 5'h00;
    end
    // data toggles outside the done pulse so a stale word never matches
    always @(posedge clk) begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        conv_chan <= ~conv_chan;
        if (conv_start) cnt <= 3;
        else if (cnt > 0) cnt <= cnt - 1;
        if (cnt == 1) begin
            conv_done <= 1'b1;
            conv_data <= data_in;
            conv_chan <= chan_in;
        end
    end
endmodule // asc_core_model

// ---- testbench/asc_ctl_bench.sv ----
`timescale 1ns/1ps
module asc_ctl_bench;
    localparam logic [15:0] ON = 16'h8000, SIDL = 16'h2000, BM = 16'h1000, R12 = 16'h0400;
    localparam logic [15:0] SIM = 16'h0008, AUTO_SAMPLE_START = 16'h0004, SAMPLE_CONTROL = 16'h0002, DONE = 16'h0001;
    localparam logic [15:0] REXP [8] = '{16'h37e4, 16'he43f, 16'h9fff, 16'h0007, 16'h0, 16'h0, 16'h0, 16'h0};
    typedef struct packed {logic r12; logic [1:0] fmt; logic [11:0] raw; logic [15:0] res;} asc_row_s;
    localparam asc_row_s ROWS [6] = '{'{1'b0, 2'h0, 12'h2ab, 16'h02ab}, '{1'b0, 2'h1, 12'h155, 16'hff55},
        '{1'b0, 2'h2, 12'h155, 16'h0155}, '{1'b1, 2'h0, 12'habc, 16'h0abc},
        '{1'b1, 2'h1, 12'h3bc, 16'hfbbc}, '{1'b1, 2'h1, 12'hbbc, 16'h03bc}};
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [2:0]  reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        idle_mode = 1'b0;
    logic        external_interrupt_zero = 1'b0;
    logic        timer_cmp = 1'b0;
    logic        conv_done, conv_start, sh_sample, res_12bit, simul_sample, conv_irq_flag, dma_req;
    logic [11:0] conv_data, dma_addr, last_dma;
    logic [11:0] m_data = 12'h000;
    logic [4:0]  conv_chan;
    logic [4:0]  m_chan = 5'h00;
    logic [15:0] reg_rdata, result_word, v, cfg;
    int          n_fail = 0, checked = 0, n_irq = 0, cyc = 0, n_st;
    bit          found;

    asc_ctl #(.UNIT(1)) asc_ctl_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_mode(idle_mode),
        .external_interrupt_zero(external_interrupt_zero), .timer_cmp(timer_cmp), .conv_done(conv_done),
        .conv_data(conv_data), .conv_chan(conv_chan), .sh_sample(sh_sample), .conv_start(conv_start),
        .res_12bit(res_12bit), .simul_sample(simul_sample), .result_word(result_word),
        .conv_irq_flag(conv_irq_flag), .dma_req(dma_req), .dma_addr(dma_addr));
    asc_core_model asc_core_model_i (.clk(clk), .conv_start(conv_start), .data_in(m_data), .chan_in(m_chan),
        .conv_done(conv_done), .conv_data(conv_data), .conv_chan(conv_chan));

    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (conv_irq_flag === 1'b1) n_irq++;
        if (conv_irq_flag === 1'b1) last_dma = dma_addr;
        if (!sys_rst && dma_req !== conv_irq_flag) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, dma_req, conv_irq_flag);
        end
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // the start pulse may already stand when called right after the trigger edge
    task automatic wait_start(input int n, output bit f);
        f = 1'b0;
        for (int i = 0; i < n && !f; i++) begin
            #1;
            f = (conv_start === 1'b1);
            if (!f) @(posedge clk);
        end
    endtask
    task automatic count_starts(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            c += (conv_start === 1'b1);
        end
    endtask
    // result and flags stand in the cycle after the done pulse is taken
    task automatic wait_done;
        for (int i = 0; i < 20 && conv_done !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
    endtask
    task automatic trig(input logic [2:0] code, input bit go);
        logic [15:0] c;
        c = ON | DONE | {8'h00, code, 5'h00};
        wr(asc_pkg::REG_CON1, c & ~ON);
        wr(asc_pkg::REG_CON1, c);
        wr(asc_pkg::REG_CON1, c | SAMPLE_CONTROL);
        count_starts(3, n_st);
        chk({15'h0, sh_sample}, 16'h0001);
        chk(n_st[15:0], 16'h0000);
        @(posedge clk);
        external_interrupt_zero <= (code == asc_pkg::TRG_EXT_INT);
        timer_cmp <= (code == asc_pkg::TRG_TIMER);
        @(posedge clk);
        timer_cmp <= 1'b0;
        wait_start(10, found);
        chk({15'h0, found}, {15'h0, go});
        if (found) chk({15'h0, sh_sample}, 16'h0000);
        if (found) wait_done();
        @(posedge clk);
        external_interrupt_zero <= 1'b0;
        wr(asc_pkg::REG_CON1, 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        chk({10'h0, sh_sample, conv_start, res_12bit, simul_sample, conv_irq_flag, dma_req}, 16'h0000);
        for (int a = 0; a < 8; a++) wr(a[2:0], (a == 0) ? 16'h37fc : 16'hffff);
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], v);
            chk(v, REXP[a]);
        end
        chk({15'h0, res_12bit}, 16'h0001);
        wr(asc_pkg::REG_CON1, 16'h0000);
        rd(asc_pkg::REG_CON2, v);
        chk(v, 16'he73f);
        for (int a = 1; a < 4; a++) wr(a[2:0], 16'h0000);
        $display("registers done");
        foreach (ROWS[i]) begin
            cfg = DONE | SIM | (ROWS[i].r12 ? R12 : 16'h0000) | {6'h0, ROWS[i].fmt, 8'h00};
            m_data = ROWS[i].raw;
            wr(asc_pkg::REG_CON1, cfg);
            wr(asc_pkg::REG_CON1, cfg | ON);
            chk({15'h0, res_12bit}, {15'h0, ROWS[i].r12});
            chk({15'h0, simul_sample}, {15'h0, ~ROWS[i].r12});
            wr(asc_pkg::REG_CON1, cfg | ON | SAMPLE_CONTROL);
            wr(asc_pkg::REG_CON1, cfg | ON);
            wait_start(5, found);
            chk({15'h0, found}, 16'h0001);
            rd(asc_pkg::REG_CON1, v);
            chk({15'h0, v[0]}, 16'h0000);
            wait_done();
            chk(result_word, ROWS[i].res);
            chk({15'h0, conv_irq_flag}, 16'h0001);
            rd(asc_pkg::REG_CON1, v);
            chk({15'h0, v[0]}, 16'h0001);
            wr(asc_pkg::REG_CON1, cfg);
        end
        $display("formats done");
        wr(asc_pkg::REG_CON1, 16'h0000);
        wr(asc_pkg::REG_CON3, 16'h0800);
        trig(asc_pkg::TRG_EXT_INT, 1'b1);
        trig(asc_pkg::TRG_TIMER, 1'b1);
        trig(asc_pkg::TRG_COUNTER, 1'b1);
        for (int c = 3; c < 7; c++) trig(c[2:0], 1'b0);
        $display("triggers done");
        wr(asc_pkg::REG_CON2, 16'h0004);
        wr(asc_pkg::REG_CON3, 16'h0200);
        wr(asc_pkg::REG_CON4, 16'h0002);
        m_chan = 5'h05;
        n_irq = 0;
        cfg = AUTO_SAMPLE_START | {8'h00, asc_pkg::TRG_COUNTER, 5'h00};
        wr(asc_pkg::REG_CON1, cfg | ON);
        n_st = 0;
        for (int i = 0; i < 200 && n_st < 4; i++) begin
            @(posedge clk);
            #1;
            n_st += (conv_start === 1'b1);
        end
        wait_done();
        @(posedge clk);
        #1;
        chk(n_irq[15:0], 16'h0002);
        chk({4'h0, last_dma}, 16'h0015);
        wr(asc_pkg::REG_CON1, cfg);
        $display("auto group done");
        last_dma = 12'hfff;
        @(posedge clk);
        idle_mode <= 1'b1;
        wr(asc_pkg::REG_CON1, cfg | SIDL | BM | ON);
        count_starts(30, n_st);
        chk(n_st[15:0], 16'h0000);
        @(posedge clk);
        idle_mode <= 1'b0;
        count_starts(60, n_st);
        chk({15'h0, n_st > 0}, 16'h0001);
        chk({4'h0, last_dma}, 16'h0001);
        wr(asc_pkg::REG_CON1, cfg | BM | ON);
        @(posedge clk);
        idle_mode <= 1'b1;
        count_starts(40, n_st);
        chk({15'h0, n_st > 0}, 16'h0001);
        wr(asc_pkg::REG_CON1, cfg);
        count_starts(30, n_st);
        chk({n_st[14:0], sh_sample}, 16'h0000);
        wr(asc_pkg::REG_CON1, cfg);
        rd(asc_pkg::REG_CON1, v);
        chk({15'h0, v[0]}, 16'h0000);
        $display("idle and off done");
        // reset in mid-run while sampling and converting
        wr(asc_pkg::REG_CON1, cfg | ON);
        repeat (10) @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        chk({10'h0, sh_sample, conv_start, res_12bit, simul_sample, conv_irq_flag, dma_req}, 16'h0000);
        rd(asc_pkg::REG_CON2, v);
        chk(v, 16'h0000);
        rd(asc_pkg::REG_CON1, v);
        chk(v, 16'h0000);
        $display("reset done");
        test_done();
    end
endmodule // asc_ctl_bench
